// ---- hw/eipr_pkg.sv ----
// Package with constants and types for the external interrupt pin and vector priority block.
package eipr_pkg;

   localparam int          NUM_VEC      = 32;
   localparam logic [4:0]  VEC_IRQ      = 5'h02;
   localparam logic [4:0]  VEC_SWI      = 5'h01;
   localparam logic [4:0]  VEC_RESET    = 5'h00;
   localparam logic [4:0]  VEC_USER_LO  = 5'h1A;
   localparam logic [15:0] VEC_BASE     = 16'hFFC0;
   localparam logic [15:0] VEC_TOP      = 16'hFFFE;

   // Register offsets on the plain register port.
   localparam logic [3:0]  OFS_PIN_CTRL = 4'h0;
   localparam logic [3:0]  OFS_IRQ_STAT = 4'h1;
   localparam logic [3:0]  OFS_IRQ_MASK = 4'h2;
   localparam logic [3:0]  OFS_SRC_EN   = 4'h3;
   localparam logic [3:0]  OFS_PEND     = 4'h4;
   localparam logic [3:0]  OFS_VECTOR   = 4'h5;
   localparam logic [3:0]  OFS_CORE     = 4'h6;

   // Bit positions of the pin status and control register.
   localparam int          BIT_MODE     = 0;
   localparam int          BIT_IE       = 1;
   localparam int          BIT_ACK      = 2;
   localparam int          BIT_FLAG     = 3;
   localparam int          BIT_PE       = 4;
   localparam int          BIT_EDG      = 5;

   // Bit positions of the core register.
   localparam int          BIT_GMASK    = 0;
   localparam int          BIT_STACK    = 1;

   // Interrupt status bits of this block.
   localparam int          EV_PIN       = 0;
   localparam int          EV_VECTOR    = 1;

   localparam logic [7:0]  PIN_CTRL_RST = 8'h00;
   localparam int          STACK_BYTES  = 5;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } eipr_bus_req_t;

   typedef enum logic [2:0] {
      STK_PCL,
      STK_PCH,
      STK_X,
      STK_A,
      STK_CCR
   } eipr_stack_t;

   typedef enum {
      CS_IDLE,
      CS_STACK,
      CS_FETCH_HI,
      CS_FETCH_LO
   } eipr_state_t;

endpackage : eipr_pkg

// ---- hw/eipr_core.sv ----
// External interrupt pin logic with request qualification, priority and vector fetch sequencing.
//
// Function
// RULE1 - Pin acts only while enable bit set
// RULE2 - Software selects pin event polarity
// RULE3 - Edge-only or edge-and-level sensing selectable
// RULE4 - Event raises interrupt or only sets flag
// RULE5 - Rising-edge setting selects pulldown not pullup
// RULE6 - Pin level visible for branch instructions
// RULE7 - Deasserted to asserted transition sets flag
// RULE8 - Level mode holds flag while asserted
// RULE9 - Lowest vector number wins, zero highest
// RULE10 - Vector high byte at lower address
// RULE11 - Forward request when flag and enable set
// RULE12 - Unmasked: stack five bytes, mask, fetch
// RULE13 - Vectors 26 to 31 have no source
// RULE14 - Polarity zero falling/low, one rising/high
// RULE15 - Enabled pin switches pullup or pulldown
// RULE16 - Asynchronous pin path wakes from stop; here stop_wake_o is registered from the synchronised level
// RULE17 - Global mask set after reset
// RULE18 - Pin synchronised before detection
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module eipr_core
   import eipr_pkg::*;
(
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              reset_n_i,
   // Register port.
   input  wire eipr_bus_req_t     bus_req_i,
   output logic [31:0]            bus_rdata_o,
   // Interrupt pin and pad controls.
   input  wire logic              irq_pin_i,
   output logic                   pad_pullup_en_o,
   output logic                   pad_pulldown_en_o,
   output logic                   stop_wake_o,
   // Core side.
   input  wire logic              stop_mode_i,
   input  wire logic              instr_done_i,
   input  wire logic              clear_gmask_i,
   input  wire logic [31:0]       src_flags_i,
   output logic                   pin_level_o,
   output logic                   branch_if_pin_high_o,
   output logic                   branch_if_pin_low_o,
   output logic                   stack_wr_o,
   output logic [2:0]             stack_sel_o,
   output logic                   vec_rd_o,
   output logic [15:0]            vec_addr_o,
   output logic [4:0]             vec_num_o,
   output logic                   global_mask_o,
   // Interrupt output.
   output logic                   irq_o
);

   logic [2:0]  sync_r;
   logic        level_r;
   logic        pin_function_enable_r;
   logic        edge_polarity_select_r;
   logic        level_sense_mode_r;
   logic        pin_interrupt_enable_r;
   logic        pin_event_flag_r;
   logic [1:0]  stat_r;
   logic [1:0]  mask_r;
   logic [31:0] src_en_r;
   logic        gmask_r;
   eipr_state_t state_r;
   logic [2:0]  stk_cnt_r;
   logic [4:0]  win_r;
   logic        asserted;
   logic        rise_evt;
   logic        ack_wr;
   logic [31:0] pend;
   logic        any_pend;
   logic [4:0]  win;
   logic        vec_evt;

   // Lowest set bit index gives the highest priority source.
   function automatic logic [4:0] first_set(input logic [31:0] v);
      logic [4:0] idx;
      idx = 5'h1F;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 5'(i);
         end
      end
      return idx;
   endfunction : first_set

   function automatic logic wr_hit(input eipr_bus_req_t r, input logic [3:0] ofs);
      return r.wr && (r.addr == ofs);
   endfunction : wr_hit

   // Three stages; a change counts once the second and third agree.
   // Stages start at the pulled-up idle level so that no false edge follows reset.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync_r <= 3'h7;
      end else begin
         sync_r <= {sync_r[1:0], irq_pin_i}; // RULE18
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         level_r <= 1'b1;
      end else if (sync_r[1] == sync_r[2]) begin
         level_r <= sync_r[2]; // RULE18
      end
   end

   // Polarity 1 means rising/high, 0 means falling/low.
   assign asserted = pin_function_enable_r && (level_r == edge_polarity_select_r); // RULE1 RULE2 RULE14
   assign rise_evt = pin_function_enable_r && (sync_r[1] == sync_r[2])
                     && (sync_r[2] == edge_polarity_select_r) && (level_r != edge_polarity_select_r); // RULE7
   assign ack_wr   = wr_hit(bus_req_i, OFS_PIN_CTRL) && bus_req_i.wdata[BIT_ACK];

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_function_enable_r  <= PIN_CTRL_RST[BIT_PE];
         edge_polarity_select_r <= PIN_CTRL_RST[BIT_EDG];
         level_sense_mode_r     <= PIN_CTRL_RST[BIT_MODE];
         pin_interrupt_enable_r <= PIN_CTRL_RST[BIT_IE];
      end else if (wr_hit(bus_req_i, OFS_PIN_CTRL)) begin
         pin_function_enable_r  <= bus_req_i.wdata[BIT_PE]; // RULE1
         edge_polarity_select_r <= bus_req_i.wdata[BIT_EDG]; // RULE2
         level_sense_mode_r     <= bus_req_i.wdata[BIT_MODE]; // RULE3
         pin_interrupt_enable_r <= bus_req_i.wdata[BIT_IE]; // RULE4
      end
   end

   // Set wins over acknowledge; in level mode an asserted pin keeps the flag.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_event_flag_r <= 1'b0;
      end else if (rise_evt || (level_sense_mode_r && asserted)) begin
         pin_event_flag_r <= 1'b1; // RULE7 RULE8 RULE3
      end else if (ack_wr || !pin_function_enable_r) begin
         pin_event_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pad_pullup_en_o   <= 1'b0;
         pad_pulldown_en_o <= 1'b0;
         stop_wake_o       <= 1'b0;
      end else begin
         pad_pullup_en_o   <= pin_function_enable_r && !edge_polarity_select_r; // RULE15
         pad_pulldown_en_o <= pin_function_enable_r && edge_polarity_select_r; // RULE5 RULE15
         stop_wake_o       <= stop_mode_i && asserted; // RULE16
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_level_o          <= 1'b0;
         branch_if_pin_high_o <= 1'b0;
         branch_if_pin_low_o  <= 1'b0;
      end else begin
         pin_level_o          <= pin_function_enable_r && level_r; // RULE6
         branch_if_pin_high_o <= pin_function_enable_r && level_r; // RULE6
         branch_if_pin_low_o  <= pin_function_enable_r && !level_r; // RULE6
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         src_en_r <= 32'h0000_0000;
      end else if (wr_hit(bus_req_i, OFS_SRC_EN)) begin
         src_en_r <= bus_req_i.wdata;
      end
   end

   // Only flagged and locally enabled sources request; user vectors never do.
   always_comb begin
      pend          = src_flags_i & src_en_r; // RULE11
      pend[VEC_IRQ] = pin_event_flag_r && pin_interrupt_enable_r; // RULE4 RULE11
      for (int i = VEC_USER_LO; i < NUM_VEC; i++) begin
         pend[i] = 1'b0; // RULE13
      end
   end
   assign any_pend = |pend;
   assign win      = first_set(pend); // RULE9

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r     <= CS_IDLE;
         stk_cnt_r   <= 3'h0;
         win_r       <= 5'h00;
         gmask_r     <= 1'b1; // RULE17
         stack_wr_o  <= 1'b0;
         stack_sel_o <= 3'h0;
         vec_rd_o    <= 1'b0;
         vec_addr_o  <= 16'h0000;
         vec_num_o   <= 5'h00;
      end else begin
         stack_wr_o <= 1'b0;
         vec_rd_o   <= 1'b0;
         case (state_r)
            CS_IDLE: begin
               if (clear_gmask_i) begin
                  gmask_r <= 1'b0;
               end
               if (!gmask_r && any_pend && instr_done_i) begin // RULE12
                  state_r   <= CS_STACK;
                  stk_cnt_r <= 3'h0;
               end
            end
            CS_STACK: begin
               stack_wr_o  <= 1'b1; // RULE12
               stack_sel_o <= stk_cnt_r;
               if (stk_cnt_r == 3'(STACK_BYTES - 1)) begin
                  gmask_r <= 1'b1; // RULE12
                  win_r   <= win;
                  state_r <= CS_FETCH_HI;
               end else begin
                  stk_cnt_r <= stk_cnt_r + 3'h1;
               end
            end
            CS_FETCH_HI: begin
               vec_rd_o   <= 1'b1;
               vec_num_o  <= win_r;
               vec_addr_o <= VEC_TOP - {10'h000, win_r, 1'b0}; // RULE10
               state_r    <= CS_FETCH_LO;
            end
            CS_FETCH_LO: begin
               vec_rd_o   <= 1'b1;
               vec_addr_o <= vec_addr_o + 16'h0001; // RULE10
               state_r    <= CS_IDLE;
            end
            default: begin
               state_r <= CS_IDLE;
            end
         endcase
      end
   end

   assign global_mask_o = gmask_r;
   assign vec_evt       = (state_r == CS_FETCH_HI);

   // Sticky status: set wins over write-one-to-clear.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stat_r <= 2'h0;
         mask_r <= 2'h0;
         irq_o  <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == EV_PIN && rise_evt) || (i == EV_VECTOR && vec_evt)) begin
               stat_r[i] <= 1'b1;
            end else if (wr_hit(bus_req_i, OFS_IRQ_STAT) && bus_req_i.wdata[i]) begin
               stat_r[i] <= 1'b0;
            end
         end
         if (wr_hit(bus_req_i, OFS_IRQ_MASK)) begin
            mask_r <= bus_req_i.wdata[1:0];
         end
         irq_o <= |(stat_r & mask_r);
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_rdata_o <= 32'h0000_0000;
      end else if (bus_req_i.rd) begin
         case (bus_req_i.addr)
            OFS_PIN_CTRL: bus_rdata_o <= {26'h0, edge_polarity_select_r, pin_function_enable_r,
                                          pin_event_flag_r, 1'b0, pin_interrupt_enable_r, level_sense_mode_r};
            OFS_IRQ_STAT: bus_rdata_o <= {30'h0, stat_r};
            OFS_IRQ_MASK: bus_rdata_o <= {30'h0, mask_r};
            OFS_SRC_EN:   bus_rdata_o <= src_en_r;
            OFS_PEND:     bus_rdata_o <= pend;
            OFS_VECTOR:   bus_rdata_o <= {27'h0, win_r};
            OFS_CORE:     bus_rdata_o <= {30'h0, (state_r != CS_IDLE), gmask_r};
            default:      bus_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         bus_rdata_o <= 32'h0000_0000;
      end
   end

   chk_flag_level_hold: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (level_sense_mode_r && asserted) |=> pin_event_flag_r) else $error("flag dropped while level held"); // RULE8
   chk_reset_mask_set: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (state_r == CS_FETCH_HI) |-> gmask_r) else $error("mask not set before fetch"); // RULE12
   chk_vec_byte_order: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (state_r == CS_FETCH_HI) |=> ##1 (vec_addr_o == $past(vec_addr_o) + 16'h0001)) else $error("vector low byte misplaced"); // RULE10
   chk_user_vec_idle: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      pend[31:26] == 6'h00) else $error("user vector requested"); // RULE13
   chk_pull_exclusive: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      pin_function_enable_r |=> (pad_pullup_en_o != pad_pulldown_en_o)) else $error("pull select wrong"); // RULE15
   chk_disabled_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      !pin_function_enable_r |=> !pin_event_flag_r) else $error("flag set while pin disabled"); // RULE1
   chk_stack_five: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      $rose(state_r == CS_STACK) |-> (state_r == CS_STACK) [*5] ##1 (state_r == CS_FETCH_HI)) else $error("stack length wrong"); // RULE12
   chk_mask_blocks: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      (state_r == CS_IDLE && gmask_r) |=> (state_r == CS_IDLE)) else $error("masked request taken"); // RULE17

endmodule : eipr_core
`default_nettype wire

// ---- dv/eipr_pin_src.sv ----
// Behavioural source that drives the external interrupt pin, with pad pulls when released.
`timescale 1ns/1ps
`default_nettype none
module eipr_pin_src (
   // Clock.
   input  wire logic clk_i,
   // Commanded drive.
   input  wire logic drv_en_i,
   input  wire logic drv_lvl_i,
   // Pad pulls from the block.
   input  wire logic pull_up_i,
   input  wire logic pull_down_i,
   // Pin level.
   output logic      pin_o
);
   logic last_r = 1'b0;

   always @(posedge clk_i) begin
      if (drv_en_i) begin
         last_r <= drv_lvl_i;
      end
   end

   // A released pin without a pull shows the inverse of its last driven level, never a stale copy.
   assign pin_o = drv_en_i ? drv_lvl_i : (pull_down_i ? 1'b0 : (pull_up_i ? 1'b1 : ~last_r));
endmodule : eipr_pin_src
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking testbench for the external interrupt pin and vector priority block.
`timescale 1ns/1ps
`default_nettype none
module tb
   import eipr_pkg::*;
;
   logic           clk_sys_i = 1'b0;
   logic           reset_n_i = 1'b0;
   eipr_bus_req_t  bus_req   = '0;
   logic [31:0]    bus_rdata, src_flags = '0, rv;
   logic           stop_mode = 1'b0, instr_done = 1'b0, clear_gmask = 1'b0;
   logic           pin_drv = 1'b1, pin_lvl = 1'b1, irq_pin, pull_up, pull_down, stop_wake;
   logic           pin_level, br_high, br_low, stack_wr, vec_rd, gmask, irq;
   logic [2:0]     stack_sel;
   logic [15:0]    vec_addr;
   logic [4:0]     vec_num;
   logic [2:0]     sel_q[$];
   logic [15:0]    addr_q[$];
   int             error_cnt = 0;
   int             cmp_count = 0;

   always #2 clk_sys_i = ~clk_sys_i;

   eipr_core uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .bus_req_i(bus_req), .bus_rdata_o(bus_rdata),
      .irq_pin_i(irq_pin), .pad_pullup_en_o(pull_up), .pad_pulldown_en_o(pull_down), .stop_wake_o(stop_wake),
      .stop_mode_i(stop_mode), .instr_done_i(instr_done), .clear_gmask_i(clear_gmask), .src_flags_i(src_flags),
      .pin_level_o(pin_level), .branch_if_pin_high_o(br_high), .branch_if_pin_low_o(br_low),
      .stack_wr_o(stack_wr), .stack_sel_o(stack_sel), .vec_rd_o(vec_rd), .vec_addr_o(vec_addr),
      .vec_num_o(vec_num), .global_mask_o(gmask), .irq_o(irq));

   eipr_pin_src src (.clk_i(clk_sys_i), .drv_en_i(pin_drv), .drv_lvl_i(pin_lvl), .pull_up_i(pull_up),
      .pull_down_i(pull_down), .pin_o(irq_pin));

   // Records every stacked byte and vector fetch as the core walks its entry sequence.
   always @(negedge clk_sys_i) begin
      if (stack_wr === 1'b1) begin
         sel_q.push_back(stack_sel);
      end
      if (vec_rd === 1'b1) begin
         addr_q.push_back(vec_addr);
      end
   end

   task automatic close_out;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys_i);
      bus_req <= '0;
   endtask : wr

   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys_i);
      bus_req <= '0;
      @(negedge clk_sys_i);
      rv = bus_rdata;
      chk(nm, rv, exp);
      @(posedge clk_sys_i);
   endtask : rchk

   task automatic pin(input logic v);
      @(posedge clk_sys_i);
      pin_lvl <= v;
      cyc(8);
   endtask : pin

   // One-cycle strobe on the instruction boundary input, or on the mask clear input.
   task automatic pulse(input bit to_done);
      @(posedge clk_sys_i);
      if (to_done) begin
         instr_done <= 1'b1;
      end else begin
         clear_gmask <= 1'b1;
      end
      @(posedge clk_sys_i);
      instr_done  <= 1'b0;
      clear_gmask <= 1'b0;
      cyc(2);
   endtask : pulse

   initial begin
      #8000;
      error_cnt++;
      close_out();
   end

   initial begin
      cyc(3);
      reset_n_i <= 1'b1;
      chk("gmask_rst", gmask, 1'b1);
      rchk("core_rst", OFS_CORE, 32'h0000_0001);
      rchk("ctrl_rst", OFS_PIN_CTRL, 32'h0000_0000);
      rchk("unmapped", 4'hF, 32'h0000_0000);
      chk("pulls_off", {pull_up, pull_down}, 2'b00);
      src_flags <= 32'hFC00_0028;
      wr(OFS_SRC_EN, 32'hFC00_0028);
      pulse(1'b1);
      cyc(10);
      chk("masked_stack", sel_q.size(), 0);
      src_flags <= 32'h0000_0000;
      pin(1'b0);
      pin(1'b1);
      rchk("pin_off_flag", OFS_PIN_CTRL, 32'h0000_0000);
      chk("pin_off_lvl", pin_level, 1'b0);
      wr(OFS_PIN_CTRL, 32'h0000_0010);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      cyc(2);
      chk("pull_fall", {pull_up, pull_down}, 2'b10);
      pin(1'b0);
      rchk("fall_flag", OFS_PIN_CTRL, 32'h0000_0018);
      chk("lvl_low", {pin_level, br_high, br_low}, 3'b001);
      rchk("poll_only", OFS_PEND, 32'h0000_0000);
      wr(OFS_PIN_CTRL, 32'h0000_0012);
      rchk("pend_pin", OFS_PEND, 32'h0000_0004);
      chk("irq_set", irq, 1'b1);
      wr(OFS_IRQ_STAT, 32'h0000_0001);
      cyc(2);
      chk("irq_clr", irq, 1'b0);
      wr(OFS_PIN_CTRL, 32'h0000_0014);
      rchk("edge_ack", OFS_PIN_CTRL, 32'h0000_0010);
      pin(1'b1);
      rchk("rise_ignored", OFS_PIN_CTRL, 32'h0000_0010);
      wr(OFS_PIN_CTRL, 32'h0000_0031);
      cyc(2);
      chk("pull_rise", {pull_up, pull_down}, 2'b01);
      pin(1'b0);
      wr(OFS_PIN_CTRL, 32'h0000_0035);
      rchk("rise_armed", OFS_PIN_CTRL, 32'h0000_0031);
      pin(1'b1);
      rchk("rise_flag", OFS_PIN_CTRL, 32'h0000_0039);
      chk("irq_rise", irq, 1'b1);
      chk("lvl_high", {pin_level, br_high, br_low}, 3'b110);
      wr(OFS_PIN_CTRL, 32'h0000_0035);
      rchk("level_hold", OFS_PIN_CTRL, 32'h0000_0039);
      stop_mode <= 1'b1;
      cyc(3);
      chk("stop_wake", stop_wake, 1'b1);
      stop_mode <= 1'b0;
      pin_drv   <= 1'b0;
      cyc(8);
      chk("pull_release", {pin_level, br_low}, 2'b01);
      wr(OFS_PIN_CTRL, 32'h0000_0035);
      rchk("level_ack", OFS_PIN_CTRL, 32'h0000_0031);
      wr(OFS_PIN_CTRL, 32'h0000_0000);
      src_flags <= 32'hFC00_0028;
      rchk("pend_src", OFS_PEND, 32'h0000_0028);
      pulse(1'b0);
      chk("gmask_clr", gmask, 1'b0);
      pulse(1'b1);
      cyc(20);
      chk("stack_cnt", sel_q.size(), STACK_BYTES);
      for (int i = 0; i < 5; i++) begin
         chk("stack_sel", sel_q[i], i);
      end
      chk("fetch_cnt", addr_q.size(), 2);
      chk("vec_hi", addr_q[0], VEC_TOP - 16'h0006);
      chk("vec_lo", addr_q[1], VEC_TOP - 16'h0005);
      chk("winner", vec_num, 5'h03);
      chk("gmask_set", gmask, 1'b1);
      rchk("last_win", OFS_VECTOR, 32'h0000_0003);
      close_out();
   end
endmodule : tb
`default_nettype wire
